// >>> core/dic_decoder_init_reset_config.sv
`timescale 1ns/100ps
// Contract
// - power save after hardware reset until enabled.
// - several code-rate bits make a search among them.
// - go write of 1 starts acquisition.
// - front-end swap bit exchanges I and Q before demodulation.
// - code-rate swap bit exchanges I and Q after demodulation.
// - each reset bit pulses its own full or partial reset.
// - each pulse lasts three crystal periods.
// - reset register clears itself after its pulse.
// - full resets restore defaults; partial resets keep contents.
// - only hardware reset defaults the configuration register.
// - enable bit runs device; clear returns to power save.
// - mode bits: standard, alternate 2/3, 6/7, search.
// - alternate search fixes symbol rate, ignores code-rate settings.
// - multiplier code gives 3, 4, 6 or 9.
// - crystal bit high 15 MHz, low 10 MHz.
// - nonzero system-clock register overrides derived clock.
module dic_decoder_init_reset_config
  import dic_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h0e, // arbitrary bus address
  parameter int SAMPLE_W = 6,
  parameter logic [15:0] SYMBOL_RATE_SETTING_FIXED = 16'h0000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic [SAMPLE_W-1:0] i_adc_i,
  input wire logic [SAMPLE_W-1:0] i_adc_q,
  input wire logic [SAMPLE_W-1:0] i_dem_i,
  input wire logic [SAMPLE_W-1:0] i_dem_q,
  output logic [SAMPLE_W-1:0] o_fe_i,
  output logic [SAMPLE_W-1:0] o_fe_q,
  output logic [SAMPLE_W-1:0] o_post_i,
  output logic [SAMPLE_W-1:0] o_post_q,
  output logic o_full_device_reset,
  output logic o_partial_device_reset,
  output logic o_full_demod_reset,
  output logic o_partial_demod_reset,
  output logic o_full_decoder_reset,
  output logic o_partial_decoder_reset,
  output logic o_partial_byte_align_reset,
  output logic o_partial_descrambler_reset,
  output logic o_power_save,
  output logic o_acquire_run,
  output logic [1:0] o_broadcast_mode,
  output logic o_bpsk_sel,
  output logic [3:0] o_pll_multiplier,
  output logic o_crystal_select,
  output logic o_converter_source_sel,
  output logic [8:0] o_system_clock_x2,
  output logic [15:0] o_symbol_rate,
  output logic o_symbol_rate_fixed,
  output logic [5:0] o_code_rate_mask,
  output logic o_code_rate_search
);

  if (SAMPLE_W < 1) begin : g_chk
    $error("dic_decoder_init_reset_config: SAMPLE_W must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= i_scl;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= i_sda;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  assign scl_rise = scl_sync_reg && !scl_prev_reg;
  assign scl_fall = !scl_sync_reg && scl_prev_reg;
  assign start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  assign stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two-wire slave: address byte, register address byte, then data bytes
  dic_bus_e bus_reg, bus_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [6:0] radd_reg, radd_next;
  logic iai_reg, iai_next;
  logic rw_reg, rw_next;
  logic oe_n_reg, oe_n_next;
  logic wr_en;
  logic [7:0] rd_data;

  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] rst_reg, rst_next;
  logic [7:0] sym_hi_reg, sym_hi_next;
  logic [7:0] sym_lo_reg, sym_lo_next;
  logic [7:0] code_reg, code_next;
  logic [7:0] demod_reg, demod_next;
  logic [7:0] sysclk_reg, sysclk_next;
  logic go_reg, go_next;

  always_comb begin
    bus_next = bus_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    radd_next = radd_reg;
    iai_next = iai_reg;
    rw_next = rw_reg;
    oe_n_next = oe_n_reg;
    wr_en = 1'b0;
    if (start_det) begin
      bus_next = B_ADDR;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else if (stop_det) begin
      bus_next = B_IDLE;
      oe_n_next = 1'b1;
    end else if (scl_rise) begin
      case (bus_reg)
        B_ADDR, B_RADD, B_WDATA: begin
          sh_next = {sh_reg[6:0], sda_sync_reg};
          cnt_next = cnt_reg + 4'h1;
        end
        B_RDACK: begin
          // master not-acknowledge ends the read burst
          if (sda_sync_reg) begin
            bus_next = B_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (bus_reg)
        B_ADDR: begin
          if (cnt_reg == BYTE_BITS) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              bus_next = B_AACK;
              rw_next = sh_reg[0];
              oe_n_next = 1'b0;
            end else begin
              bus_next = B_IDLE;
            end
          end
        end
        B_AACK: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            bus_next = B_RDATA;
            sh_next = rd_data;
            oe_n_next = rd_data[7];
          end else begin
            bus_next = B_RADD;
            oe_n_next = 1'b1;
          end
        end
        B_RADD: begin
          if (cnt_reg == BYTE_BITS) begin
            radd_next = sh_reg[6:0];
            iai_next = sh_reg[RADD_IAI];
            bus_next = B_RACK;
            oe_n_next = 1'b0;
          end
        end
        B_RACK: begin
          bus_next = B_WDATA;
          cnt_next = 4'h0;
          oe_n_next = 1'b1;
        end
        B_WDATA: begin
          if (cnt_reg == BYTE_BITS) begin
            wr_en = 1'b1;
            bus_next = B_WACK;
            oe_n_next = 1'b0;
          end
        end
        B_WACK: begin
          bus_next = B_WDATA;
          cnt_next = 4'h0;
          oe_n_next = 1'b1;
          if (!iai_reg) begin
            radd_next = radd_reg + 7'h01;
          end
        end
        B_RDATA: begin
          if (cnt_reg == LAST_TX_BIT) begin
            bus_next = B_RDACK;
            oe_n_next = 1'b1;
            if (!iai_reg) begin
              radd_next = radd_reg + 7'h01;
            end
          end else begin
            cnt_next = cnt_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            oe_n_next = sh_reg[6];
          end
        end
        B_RDACK: begin
          bus_next = B_RDATA;
          cnt_next = 4'h0;
          sh_next = rd_data;
          oe_n_next = rd_data[7];
        end
        default: begin
          bus_next = B_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    case (radd_reg)
      ADDR_RESET: rd_data = rst_reg;
      ADDR_SYM_HI: rd_data = sym_hi_reg;
      ADDR_SYM_LO: rd_data = sym_lo_reg;
      ADDR_CODE_RATE: rd_data = code_reg;
      ADDR_DEMOD_CTRL: rd_data = demod_reg;
      ADDR_GO: rd_data = {7'h00, go_reg};
      ADDR_SYSCLK: rd_data = sysclk_reg;
      ADDR_CONFIG: rd_data = cfg_reg;
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bus_reg <= B_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      radd_reg <= 7'h00;
      iai_reg <= 1'b0;
      rw_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      bus_reg <= bus_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      radd_reg <= radd_next;
      iai_reg <= iai_next;
      rw_reg <= rw_next;
      oe_n_reg <= oe_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse generators, one per reset register bit
  logic [7:0] pulse_start, pulse_out, pulse_done;
  logic [PULSE_CNT_W-1:0] pulse_len;
  logic full_dev, full_demod, full_dec;

  assign pulse_start = (wr_en && radd_reg == ADDR_RESET) ? sh_reg : 8'h00;
  // pulse width follows the fitted crystal
  assign pulse_len = cfg_reg[CFG_CRYSTAL] ? PULSE_CNT_W'(PULSE15_CYC) : PULSE_CNT_W'(PULSE10_CYC);

  for (genvar g = 0; g < 8; g++) begin : g_pulse
    dic_reset_pulse #(.CNT_W(PULSE_CNT_W)) u_pulse (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_start(pulse_start[g]),
      .i_len(pulse_len),
      .o_pulse(pulse_out[g]),
      .o_done(pulse_done[g])
    );
  end

  assign full_dev = pulse_out[RST_FULL_DEVICE];
  assign full_demod = pulse_out[RST_FULL_DEMOD];
  assign full_dec = pulse_out[RST_FULL_DECODER];

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    cfg_next = cfg_reg;
    // a fresh write beats the self-clear in the same cycle
    rst_next = rst_reg & ~pulse_done;
    sym_hi_next = sym_hi_reg;
    sym_lo_next = sym_lo_reg;
    code_next = code_reg;
    demod_next = demod_reg;
    sysclk_next = sysclk_reg;
    go_next = go_reg;
    if (wr_en) begin
      case (radd_reg)
        ADDR_CONFIG: cfg_next = sh_reg;
        ADDR_RESET: rst_next = rst_next | sh_reg;
        ADDR_SYM_HI: sym_hi_next = sh_reg;
        ADDR_SYM_LO: sym_lo_next = sh_reg;
        ADDR_CODE_RATE: code_next = sh_reg;
        ADDR_DEMOD_CTRL: demod_next = sh_reg;
        ADDR_SYSCLK: sysclk_next = sh_reg;
        ADDR_GO: go_next = sh_reg[0];
        default: begin
        end
      endcase
    end
    // full resets hold their registers at default; configuration untouched
    if (full_dev || full_demod) begin
      sym_hi_next = PARAM_DEF;
      sym_lo_next = PARAM_DEF;
      demod_next = PARAM_DEF;
      sysclk_next = PARAM_DEF;
    end
    if (full_dev || full_dec) begin
      code_next = PARAM_DEF;
    end
    if (full_dev) begin
      go_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cfg_reg <= CONFIG_DEF;
      rst_reg <= PARAM_DEF;
      sym_hi_reg <= PARAM_DEF;
      sym_lo_reg <= PARAM_DEF;
      code_reg <= PARAM_DEF;
      demod_reg <= PARAM_DEF;
      sysclk_reg <= PARAM_DEF;
      go_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rst_reg <= rst_next;
      sym_hi_reg <= sym_hi_next;
      sym_lo_reg <= sym_lo_next;
      code_reg <= code_next;
      demod_reg <= demod_next;
      sysclk_reg <= sysclk_next;
      go_reg <= go_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run control
  dic_run_e run_reg, run_next;
  logic go_write, dev_restart;

  assign go_write = wr_en && radd_reg == ADDR_GO && sh_reg[0];
  // full or partial device reset restarts the sequence; the partial one leaves register contents untouched
  assign dev_restart = full_dev || pulse_out[RST_PART_DEVICE];

  always_comb begin
    run_next = run_reg;
    case (run_reg)
      S_POWER_SAVE: begin
        if (cfg_reg[CFG_ENABLE]) begin
          run_next = S_IDLE;
        end
      end
      S_IDLE: begin
        if (!cfg_reg[CFG_ENABLE]) begin
          run_next = S_POWER_SAVE;
        end else if (go_write && !dev_restart) begin
          run_next = S_ACQUIRE;
        end
      end
      S_ACQUIRE: begin
        if (!cfg_reg[CFG_ENABLE]) begin
          run_next = S_POWER_SAVE;
        end else if (dev_restart) begin
          run_next = S_IDLE;
        end
      end
      default: run_next = S_POWER_SAVE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      run_reg <= S_POWER_SAVE;
    end else begin
      run_reg <= run_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived settings, registered straight onto the outputs
  logic [3:0] mult_next, mult_reg;
  logic [8:0] xtal_x2, clk_x2_next, clk_x2_reg;
  logic [15:0] sym_next, sym_reg;
  logic [5:0] mask_next, mask_reg;
  logic fixed_next, fixed_reg, search_next, search_reg;
  logic [1:0] mode;

  assign mode = cfg_reg[CFG_MODE_HI:CFG_MODE_LO];

  always_comb begin
    case (cfg_reg[CFG_PLL_HI:CFG_PLL_LO])
      2'h0: mult_next = PLL_MULT_0;
      2'h1: mult_next = PLL_MULT_1;
      2'h2: mult_next = PLL_MULT_2;
      default: mult_next = PLL_MULT_3;
    endcase
    xtal_x2 = cfg_reg[CFG_CRYSTAL] ? XTAL15_MHZ_X2 : XTAL10_MHZ_X2;
    // largest product is 270, so nine bits never overflow
    clk_x2_next = (sysclk_reg != PARAM_DEF) ? {1'b0, sysclk_reg} : xtal_x2 * {5'h00, mult_next};
    fixed_next = (mode == MODE_ALT_SEARCH);
    sym_next = fixed_next ? SYMBOL_RATE_SETTING_FIXED : {sym_hi_reg, sym_lo_reg};
    case (mode)
      MODE_STANDARD: mask_next = code_reg[CODE_MASK_HI:0];
      MODE_ALT_2_3: mask_next = CR_MASK_2_3;
      MODE_ALT_6_7: mask_next = CR_MASK_6_7;
      default: mask_next = CR_MASK_ALT_SEARCH;
    endcase
    search_next = fixed_next || ($countones(mask_next) > 1);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mult_reg <= PLL_MULT_0;
      clk_x2_reg <= 9'h000;
      sym_reg <= 16'h0000;
      mask_reg <= 6'h00;
      fixed_reg <= 1'b0;
      search_reg <= 1'b0;
    end else begin
      mult_reg <= mult_next;
      clk_x2_reg <= clk_x2_next;
      sym_reg <= sym_next;
      mask_reg <= mask_next;
      fixed_reg <= fixed_next;
      search_reg <= search_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I and Q exchange before and after demodulation
  dic_iq_swap #(.W(SAMPLE_W)) u_fe_swap (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_swap(demod_reg[IQ_SWAP_BIT]),
    .i_i(i_adc_i),
    .i_q(i_adc_q),
    .o_i(o_fe_i),
    .o_q(o_fe_q)
  );

  dic_iq_swap #(.W(SAMPLE_W)) u_post_swap (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_swap(code_reg[IQ_SWAP_BIT]),
    .i_i(i_dem_i),
    .i_q(i_dem_q),
    .o_i(o_post_i),
    .o_q(o_post_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic sda_out_reg;

  always_ff @(posedge i_clk_sys) begin
    sda_out_reg <= 1'b0;
  end

  assign o_sda_out = sda_out_reg;
  assign o_sda_oe_n = oe_n_reg;
  assign {o_full_device_reset, o_partial_device_reset, o_full_demod_reset, o_partial_demod_reset} = pulse_out[7:4];
  assign {o_full_decoder_reset, o_partial_decoder_reset} = pulse_out[3:2];
  assign {o_partial_byte_align_reset, o_partial_descrambler_reset} = pulse_out[1:0];
  assign o_power_save = run_reg[0];
  assign o_acquire_run = run_reg[2];
  assign o_broadcast_mode = mode;
  assign o_bpsk_sel = cfg_reg[CFG_BPSK];
  assign o_crystal_select = cfg_reg[CFG_CRYSTAL];
  assign o_converter_source_sel = cfg_reg[CFG_CONVERTER];
  assign o_pll_multiplier = mult_reg;
  assign o_system_clock_x2 = clk_x2_reg;
  assign o_symbol_rate = sym_reg;
  assign o_symbol_rate_fixed = fixed_reg;
  assign o_code_rate_mask = mask_reg;
  assign o_code_rate_search = search_reg;

endmodule : dic_decoder_init_reset_config

// >>> core/dic_iq_swap.sv
`timescale 1ns/100ps
module dic_iq_swap #(
  parameter int W = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_swap,
  input wire logic [W-1:0] i_i,
  input wire logic [W-1:0] i_q,
  output logic [W-1:0] o_i,
  output logic [W-1:0] o_q
);

  logic [W-1:0] i_reg, i_next;
  logic [W-1:0] q_reg, q_next;

  if (W < 1) begin : g_chk
    $error("dic_iq_swap: W must be at least 1");
  end

  always_comb begin
    i_next = i_swap ? i_q : i_i;
    q_next = i_swap ? i_i : i_q;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      i_reg <= '0;
      q_reg <= '0;
    end else begin
      i_reg <= i_next;
      q_reg <= q_next;
    end
  end

  assign o_i = i_reg;
  assign o_q = q_reg;

endmodule : dic_iq_swap

// >>> core/dic_reset_pulse.sv
`timescale 1ns/100ps
module dic_reset_pulse #(
  parameter int CNT_W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_len,
  output logic o_pulse,
  output logic o_done
);

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic pulse_reg, pulse_next;
  logic done_reg, done_next;

  if (CNT_W < 1) begin : g_chk
    $error("dic_reset_pulse: CNT_W must be at least 1");
  end

  // a new start restarts the count, so back-to-back writes stretch the pulse
  always_comb begin
    cnt_next = cnt_reg;
    pulse_next = pulse_reg;
    done_next = 1'b0;
    if (i_start) begin
      pulse_next = 1'b1;
      cnt_next = i_len - {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (pulse_reg) begin
      if (cnt_reg == '0) begin
        pulse_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
      done_reg <= done_next;
    end
  end

  assign o_pulse = pulse_reg;
  assign o_done = done_reg;

endmodule : dic_reset_pulse

// >>> shared/dic_pkg.sv
package dic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (7-bit register address)
  localparam logic [6:0] ADDR_RESET = 7'h15;
  localparam logic [6:0] ADDR_SYM_HI = 7'h17;
  localparam logic [6:0] ADDR_SYM_LO = 7'h18;
  localparam logic [6:0] ADDR_CODE_RATE = 7'h19;
  localparam logic [6:0] ADDR_DEMOD_CTRL = 7'h1a;
  localparam logic [6:0] ADDR_GO = 7'h1b;
  localparam logic [6:0] ADDR_SYSCLK = 7'h22;
  localparam logic [6:0] ADDR_CONFIG = 7'h7f;

  // values after reset, and the value read at unmapped addresses
  localparam logic [7:0] CONFIG_DEF = 8'h08;
  localparam logic [7:0] PARAM_DEF = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CFG_ENABLE = 7;
  localparam int CFG_MODE_HI = 6;
  localparam int CFG_MODE_LO = 5;
  localparam int CFG_BPSK = 4;
  localparam int CFG_PLL_HI = 3;
  localparam int CFG_PLL_LO = 2;
  localparam int CFG_CRYSTAL = 1;
  localparam int CFG_CONVERTER = 0;
  localparam int IQ_SWAP_BIT = 6;
  localparam int CODE_MASK_HI = 5;
  localparam int RADD_IAI = 7;
  localparam int RST_FULL_DEVICE = 7;
  localparam int RST_PART_DEVICE = 6;
  localparam int RST_FULL_DEMOD = 5;
  localparam int RST_FULL_DECODER = 3;

  // broadcast modes and fixed code-rate masks
  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_ALT_2_3 = 2'h1;
  localparam logic [1:0] MODE_ALT_6_7 = 2'h2;
  localparam logic [1:0] MODE_ALT_SEARCH = 2'h3;
  localparam logic [5:0] CR_MASK_2_3 = 6'h02;
  localparam logic [5:0] CR_MASK_6_7 = 6'h10;
  localparam logic [5:0] CR_MASK_ALT_SEARCH = 6'h12;

  // clock multiplier codes and crystal frequency x2 in MHz
  localparam logic [3:0] PLL_MULT_0 = 4'h3;
  localparam logic [3:0] PLL_MULT_1 = 4'h4;
  localparam logic [3:0] PLL_MULT_2 = 4'h6;
  localparam logic [3:0] PLL_MULT_3 = 4'h9;
  localparam logic [8:0] XTAL10_MHZ_X2 = 9'h014;
  localparam logic [8:0] XTAL15_MHZ_X2 = 9'h01e;

  ////////////////////////////////////////////////////////////////////////////
  // timing: reset pulse is three crystal periods, rounded up to i_clk_sys
  localparam int CLK_PERIOD_PS = 25000;
  localparam int XTAL10_PERIOD_PS = 100000;
  localparam int XTAL15_PERIOD_PS = 66667;
  localparam int PULSE_XTAL_PERIODS = 3;
  localparam int PULSE10_CYC = (PULSE_XTAL_PERIODS * XTAL10_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE15_CYC = (PULSE_XTAL_PERIODS * XTAL15_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CNT_W = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [8:0] {
    B_IDLE = 9'h001, B_ADDR = 9'h002, B_AACK = 9'h004, B_RADD = 9'h008, B_RACK = 9'h010,
    B_WDATA = 9'h020, B_WACK = 9'h040, B_RDATA = 9'h080, B_RDACK = 9'h100
  } dic_bus_e;

  typedef enum logic [2:0] {
    S_POWER_SAVE = 3'h1, S_IDLE = 3'h2, S_ACQUIRE = 3'h4
  } dic_run_e;

endpackage : dic_pkg

// >>> test/dic_chk.sv
`timescale 1ns/100ps
module dic_chk
  import dic_pkg::*;
#(
  parameter int SAMPLE_W = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [SAMPLE_W-1:0] i_adc_i,
  input wire logic [SAMPLE_W-1:0] i_adc_q,
  input wire logic [SAMPLE_W-1:0] o_fe_i,
  input wire logic [SAMPLE_W-1:0] o_fe_q,
  input wire logic o_full_device_reset,
  input wire logic o_partial_device_reset,
  input wire logic o_partial_descrambler_reset,
  input wire logic o_power_save,
  input wire logic o_acquire_run,
  input wire logic [1:0] o_broadcast_mode,
  input wire logic o_crystal_select,
  input wire logic [5:0] o_code_rate_mask,
  input wire logic o_code_rate_search,
  input wire logic o_symbol_rate_fixed
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // 10 MHz crystal: 12 cycles high, 15 MHz: 9 (rounded up)
  sequence s_hi12(x); x[*8] ##1 x[*4] ##1 !x; endsequence
  sequence s_hi9(x); x[*8] ##1 x ##1 !x; endsequence
  ////////////////////////////////////////////////////////////
  AST_FULL_DEV_LEN:
    assert property ($rose(o_full_device_reset) && !o_crystal_select |-> s_hi12(o_full_device_reset))
    else $error("full reset pulse length");
  AST_DESC_LEN:
    assert property ($rose(o_partial_descrambler_reset) && o_crystal_select |-> s_hi9(o_partial_descrambler_reset))
    else $error("descrambler pulse length");
  AST_PWR_EXCL:
    assert property (o_power_save |-> !o_acquire_run)
    else $error("acquire in power save");
  AST_PART_STOP:
    assert property ($rose(o_partial_device_reset) |-> ##[0:3] !o_acquire_run)
    else $error("partial reset kept acquire");
  AST_FE_SWAP:
    assert property (!$past(i_rst) |-> (o_fe_i == $past(i_adc_i) && o_fe_q == $past(i_adc_q))
      || (o_fe_i == $past(i_adc_q) && o_fe_q == $past(i_adc_i)))
    else $error("front-end swap wrong");
  AST_ALT_SEARCH:
    assert property ((o_broadcast_mode == MODE_ALT_SEARCH)[*2] |->
      o_symbol_rate_fixed && o_code_rate_search && o_code_rate_mask == CR_MASK_ALT_SEARCH)
    else $error("search mode outputs wrong");
  AST_ALT_FIXED:
    assert property ((o_broadcast_mode == MODE_ALT_6_7)[*2] |-> o_code_rate_mask == CR_MASK_6_7 && !o_symbol_rate_fixed)
    else $error("alternate mode wrong");
  AST_CR_SEARCH:
    assert property ((o_broadcast_mode == MODE_STANDARD && $stable(o_code_rate_mask))[*2] |->
      o_code_rate_search == ($countones(o_code_rate_mask) > 1))
    else $error("search flag wrong");
endmodule : dic_chk
bind dic_decoder_init_reset_config dic_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.i_clk_sys, .i_rst, .i_adc_i, .i_adc_q,
  .o_fe_i, .o_fe_q, .o_full_device_reset, .o_partial_device_reset, .o_partial_descrambler_reset, .o_power_save,
  .o_acquire_run, .o_broadcast_mode, .o_crystal_select, .o_code_rate_mask, .o_code_rate_search, .o_symbol_rate_fixed);

// >>> test/dic_host_bfm.sv
`timescale 1ns/100ps
module dic_host_bfm #(
  parameter logic [6:0] DEV = 7'h0e
) (
  input wire logic i_clk_sys,
  input wire logic i_sda_wire,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : wt
  ////////////////////////////////////////////////////////////
  // phases of 5 clocks stay above the 3-clock sync floor
  task automatic bitx(input logic b, output logic s);
    o_sda_low <= ~b;
    wt(5);
    o_scl <= 1'b1;
    wt(5);
    s = i_sda_wire;
    o_scl <= 1'b0;
    wt(5);
  endtask : bitx
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic [8:0] v;
    v = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      bitx(v[i], v[i]);
    end
    q = v[8:1];
  endtask : xfer
  task automatic start();
    o_sda_low <= 1'b1;
    wt(5);
    o_scl <= 1'b0;
    wt(5);
  endtask : start
  task automatic stop();
    o_sda_low <= 1'b1;
    wt(5);
    o_scl <= 1'b1;
    wt(5);
    o_sda_low <= 1'b0;
    wt(5);
  endtask : stop
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({DEV, 1'b0}, q);
    xfer({1'b0, a}, q);
    xfer(d, q);
    stop();
  endtask : wr_reg
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({DEV, 1'b0}, q);
    xfer({1'b0, a}, q);
    stop();
    start();
    xfer({DEV, 1'b1}, q);
    xfer(8'hff, d);
    stop();
  endtask : rd_reg
endmodule : dic_host_bfm

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  import dic_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [5:0] i_adc_i = 6'h15, i_adc_q = 6'h2a, i_dem_i = 6'h0c, i_dem_q = 6'h33;
  logic i_scl, i_sda, o_sda_oe_n, sda_low, o_power_save, o_acquire_run, o_crystal_select, o_symbol_rate_fixed;
  logic o_code_rate_search;
  logic [5:0] o_fe_i, o_fe_q, o_post_i, o_post_q, o_code_rate_mask;
  logic [1:0] o_broadcast_mode;
  logic [3:0] o_pll_multiplier;
  logic [8:0] o_system_clock_x2;
  logic [15:0] o_symbol_rate;
  int fail_count = 0;
  int num_checks = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  assign i_sda = sda_low ? 1'b0 : o_sda_oe_n;
  dic_host_bfm host (.i_clk_sys, .i_sda_wire(i_sda), .o_scl(i_scl), .o_sda_low(sda_low));
  dic_decoder_init_reset_config DUT (.i_clk_sys, .i_rst, .i_scl, .i_sda, .o_sda_out(), .o_sda_oe_n, .i_adc_i, .i_adc_q,
    .i_dem_i, .i_dem_q, .o_fe_i, .o_fe_q, .o_post_i, .o_post_q, .o_full_device_reset(), .o_partial_device_reset(),
    .o_full_demod_reset(), .o_partial_demod_reset(), .o_full_decoder_reset(), .o_partial_decoder_reset(),
    .o_partial_byte_align_reset(), .o_partial_descrambler_reset(), .o_power_save, .o_acquire_run, .o_broadcast_mode,
    .o_bpsk_sel(), .o_pll_multiplier, .o_crystal_select, .o_converter_source_sel(), .o_system_clock_x2,
    .o_symbol_rate, .o_symbol_rate_fixed, .o_code_rate_mask, .o_code_rate_search);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    fail_count++;
    wrap_up();
  end
  initial begin
    static logic [3:0] mult [4] = '{4'h3, 4'h4, 4'h6, 4'h9};
    static logic [5:0] mask [4] = '{6'h07, 6'h02, 6'h10, 6'h12};
    static logic [8:0] sck [4] = '{9'h03c, 9'h078, 9'h078, 9'h10e};
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    host.wt(3);
    chk({o_power_save, o_acquire_run}, 2'b10);
    rchk(ADDR_CONFIG, 8'h08);
    host.wr_reg(ADDR_CONFIG, 8'h88);
    chk({o_power_save, o_pll_multiplier, o_system_clock_x2}, {1'b0, 4'h6, 9'h078});
    host.wt(6000);
    host.wr_reg(ADDR_RESET, 8'h80);
    rchk(ADDR_RESET, 8'h00);
    host.wr_reg(7'h31, 8'h32);
    host.wr_reg(ADDR_DEMOD_CTRL, 8'h40);
    chk({o_fe_i, o_fe_q}, {6'h2a, 6'h15});
    host.wr_reg(ADDR_CODE_RATE, 8'h01);
    chk({o_post_i, o_post_q, o_code_rate_mask, o_code_rate_search}, {6'h0c, 6'h33, 6'h01, 1'b0});
    host.wr_reg(ADDR_CODE_RATE, 8'h47);
    chk({o_post_i, o_post_q, o_code_rate_mask, o_code_rate_search}, {6'h33, 6'h0c, 6'h07, 1'b1});
    host.wr_reg(ADDR_GO, 8'h01);
    chk(o_acquire_run, 1'b1);
    host.wr_reg(ADDR_RESET, 8'h40);
    rchk(ADDR_DEMOD_CTRL, 8'h40);
    host.wr_reg(ADDR_RESET, 8'h20);
    rchk(ADDR_DEMOD_CTRL, 8'h00);
    rchk(ADDR_CODE_RATE, 8'h47);
    host.wr_reg(ADDR_SYM_LO, 8'h5a);
    chk(o_symbol_rate, 16'h005a);
    for (int m = 0; m < 4; m++) begin
      host.wr_reg(ADDR_CONFIG, {1'b1, 2'(m), 1'b0, 2'(m), m[0], 1'b0});
      chk({o_broadcast_mode, o_pll_multiplier, o_crystal_select, o_code_rate_mask, o_system_clock_x2},
        {2'(m), mult[m], m[0], mask[m], sck[m]});
    end
    host.wr_reg(7'h32, 8'h14);
    chk(o_symbol_rate_fixed, 1'b1);
    host.wr_reg(ADDR_RESET, 8'h01);
    host.wr_reg(ADDR_SYSCLK, 8'h7b);
    chk(o_system_clock_x2, 9'h07b);
    host.wr_reg(ADDR_RESET, 8'h80);
    rchk(ADDR_CONFIG, 8'hee);
    rchk(ADDR_SYSCLK, 8'h00);
    rchk(7'h31, 8'h00);
    host.wr_reg(ADDR_CONFIG, 8'h08);
    chk(o_power_save, 1'b1);
    wrap_up();
  end
endmodule : tb
